// *** verilog/gen_ctl_defs.svh ***
`ifndef GEN_CTL_DEFS_SVH
`define GEN_CTL_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_MIN_RUN 8'h04
`define REG_WARM 8'h08
`define REG_COOL 8'h0c
`define REG_SVC_INT 8'h10
`define REG_TOTAL_SET 8'h14
`define REG_CMD 8'h18
`define REG_STATUS 8'h1c
`define REG_RUN_TIME 8'h20
`define REG_TOTAL 8'h24
`define REG_SVC_LEFT 8'h28
`define REG_DAY_BASE 8'h40

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_AUTO 0
`define CTRL_MANUAL 1
`define CTRL_DETECT 2
`define CTRL_NOAUTO_ALM 3
`define CTRL_LOSS_LO 4
`define CTRL_LOSS_HI 5
`define CTRL_GRID_LO 6
`define CTRL_GRID_HI 7
`define CTRL_RESET 32'h0000_0001

// ----------------------------------------
// command bits
// ----------------------------------------
`define CMD_SVC_RESET 0
`define CMD_DAY_RESET 1
`define CMD_DAY_ROLL 2

// ----------------------------------------
// reset values and times
// ----------------------------------------
`define MIN_RUN_RESET 32'h0000_0000
`define WARM_RESET 32'h0000_003c
`define COOL_RESET 32'h0000_00b4
`define SVC_INT_RESET 32'h0000_0000
`define NOAUTO_LIMIT_S 600
`define GRID_EXTRA_S 15
`define CLK_HZ 100000000

`endif

// *** verilog/gen_ctl_pkg.sv ***
package gen_ctl_pkg;

  typedef enum logic [5:0] {
    ST_STOPPED = 6'h01,
    ST_WARMUP = 6'h02,
    ST_MANUAL = 6'h04,
    ST_COND = 6'h08,
    ST_COOL = 6'h10,
    ST_STOPPING = 6'h20
  } run_state_type;

  typedef enum logic [1:0] {
    LOSS_STOP = 2'h0,
    LOSS_START = 2'h1,
    LOSS_KEEP = 2'h2
  } loss_action_type;

  typedef enum logic [1:0] {
    GRID_OFF = 2'h0,
    GRID_AC1 = 2'h1,
    GRID_AC2 = 2'h2
  } grid_stop_type;

endpackage

// *** verilog/sec_tick.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// one-second time base
// ----------------------------------------
module sec_tick #(
  parameter int unsigned DIV = 100000000
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  output logic tick_out
);
  logic [31:0] cnt_q;

  // divider wraps once a second
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || cnt_q == 32'(DIV - 1)) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  // pulse on wrap
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= (cnt_q == 32'(DIV - 1));
    end
  end
endmodule

// *** verilog/cond_arbiter.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// ranked start-condition arbiter
// ----------------------------------------
module cond_arbiter (
  input wire logic [8:0] demand_in,
  output logic [8:0] active_out,
  output logic any_out,
  output logic lower_out
);
  logic [8:0] seen;

  // bit 8 manual ranks highest, bit 0 periodic lowest
  always_comb begin
    seen = 9'h000;
    active_out = 9'h000;
    for (int i = 8; i >= 0; i--) begin
      if (demand_in[i] && seen == 9'h000) begin
        active_out[i] = 1'b1;
      end
      seen[i] = demand_in[i];
    end
  end

  assign any_out = |demand_in;
  // some condition ranked below the active one still demands
  assign lower_out = |(demand_in & ~active_out);
endmodule

// *** verilog/gen_autostart.sv ***
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/10ps
// Function
// - Exactly one of six run states is reported at all times.
// - Current-run timer restarts at each start and counts run seconds.
// - Total run counter accumulates; a total-hours write overwrites it.
// - Service countdown from interval hours; warning raised on expiry.
// - Service reset command reloads countdown from interval.
// - Seven daily run-time totals kept, newest in day zero.
// - Daily reset command clears all seven day totals.
// - Condition starts and stops only while autostart is enabled.
// - Condition start holds at least minimum run time once past warm-up; manual ignores it.
// - Warm-up and cool-down run relay with AC input relay open.
// - Detection enabled: alarm when running expected but no AC input power.
// - No-autostart alarm after autostart off over ten minutes.
// - Comms loss applies stop, start or keep-running action.
// - Conditions ranked manual, AC-in, SoC, load, current, voltage, temp, overload, periodic.
// - Only the highest met condition is reported active.
// - All enabled conditions evaluated continuously, also while running.
// - Lower-ranked demand keeps generator running after active one clears.
// - Grid-return stop setting: disabled, AC input 1 or AC input 2.
// - Grid return: disconnect, cool down, then 15 s before stopped.
// - Manual start while running suppresses auto-stop until withdrawn.
`include "gen_ctl_defs.svh"

module gen_autostart #(
  parameter int unsigned CLK_HZ = `CLK_HZ,
  parameter int unsigned DAYS = 7
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [6:0] cond_demand_in,
  input wire logic comm_lost_in,
  input wire logic ac_power_in,
  input wire logic grid_ac1_in,
  input wire logic grid_ac2_in,
  output logic relay_out,
  output logic ac_connect_out,
  output logic [5:0] state_out,
  output logic [8:0] active_cond_out,
  output logic service_warn_out,
  output logic no_power_alarm_out,
  output logic no_auto_alarm_out
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [9:0] sync1_q;
  logic [9:0] sync2_q;

  // two stages for every external level
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
    end else begin
      sync1_q <= {cond_demand_in, comm_lost_in, ac_power_in, grid_ac1_in};
      sync2_q <= sync1_q;
    end
  end

  logic grid2_s1_q;
  logic grid2_s2_q;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      grid2_s1_q <= 1'b0;
      grid2_s2_q <= 1'b0;
    end else begin
      grid2_s1_q <= grid_ac2_in;
      grid2_s2_q <= grid2_s1_q;
    end
  end

  logic [6:0] cond_s;
  logic comm_lost_s;
  logic ac_power_s;
  assign cond_s = sync2_q[9:3];
  assign comm_lost_s = sync2_q[2];
  assign ac_power_s = sync2_q[1];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] min_run_q;
  logic [31:0] warm_q;
  logic [31:0] cool_q;
  logic [31:0] svc_int_q;
  logic wr_total;
  logic svc_reset;
  logic day_reset;
  logic day_roll;

  assign wr_total = wr_in && addr_in == `REG_TOTAL_SET;
  assign svc_reset = wr_in && addr_in == `REG_CMD && wdata_in[`CMD_SVC_RESET];
  assign day_reset = wr_in && addr_in == `REG_CMD && wdata_in[`CMD_DAY_RESET];
  assign day_roll = wr_in && addr_in == `REG_CMD && wdata_in[`CMD_DAY_ROLL];

  // settings written by software
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ctrl_q <= `CTRL_RESET;
      min_run_q <= `MIN_RUN_RESET;
      warm_q <= `WARM_RESET;
      cool_q <= `COOL_RESET;
      svc_int_q <= `SVC_INT_RESET;
    end else if (wr_in) begin
      case (addr_in)
        `REG_CTRL: begin
          ctrl_q <= {24'h000000, wdata_in[7:0]};
        end
        `REG_MIN_RUN: begin
          min_run_q <= wdata_in;
        end
        `REG_WARM: begin
          warm_q <= wdata_in;
        end
        `REG_COOL: begin
          cool_q <= wdata_in;
        end
        `REG_SVC_INT: begin
          svc_int_q <= wdata_in;
        end
        default: begin
        end
      endcase
    end
  end

  logic auto_en;
  logic manual_req;
  logic [1:0] loss_act;
  logic [1:0] grid_sel;
  assign auto_en = ctrl_q[`CTRL_AUTO];
  assign manual_req = ctrl_q[`CTRL_MANUAL];
  assign loss_act = ctrl_q[`CTRL_LOSS_HI:`CTRL_LOSS_LO];
  assign grid_sel = ctrl_q[`CTRL_GRID_HI:`CTRL_GRID_LO];

  // ----------------------------------------
  // time base and conditions
  // ----------------------------------------
  logic tick;
  sec_tick #(
    .DIV(CLK_HZ)
  ) u_tick (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .tick_out(tick)
  );

  logic grid_back;
  assign grid_back = (grid_sel == gen_ctl_pkg::GRID_AC1 && sync2_q[0]) ||
    (grid_sel == gen_ctl_pkg::GRID_AC2 && grid2_s2_q);

  // conditions gated by autostart; loss start joins them
  logic [8:0] demand;
  logic loss_start;
  assign loss_start = comm_lost_s && loss_act == gen_ctl_pkg::LOSS_START;
  assign demand = {manual_req, 1'b0,
    (auto_en ? cond_s : 7'h00) | {6'h00, auto_en & loss_start}};

  logic any_demand;
  logic lower_demand;
  cond_arbiter u_arb (
    .demand_in(demand),
    .active_out(active_cond_out),
    .any_out(any_demand),
    .lower_out(lower_demand)
  );

  // ----------------------------------------
  // run state machine
  // ----------------------------------------
  gen_ctl_pkg::run_state_type state_q;
  logic [31:0] phase_q;
  logic by_manual_q;
  logic [31:0] run_s_q;

  logic keep_run;
  logic loss_stop;
  // any remaining demand holds; manual blocks auto-stop
  assign keep_run = any_demand || lower_demand || manual_req;
  // stop on loss only when the stop action is chosen and no manual request
  assign loss_stop = comm_lost_s && loss_act == gen_ctl_pkg::LOSS_STOP && !manual_req;

  logic min_done;
  // minimum run only after condition start
  assign min_done = by_manual_q || run_s_q >= min_run_q;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= gen_ctl_pkg::ST_STOPPED;
      phase_q <= 32'h0000_0000;
      by_manual_q <= 1'b0;
    end else begin
      case (state_q)
        gen_ctl_pkg::ST_STOPPED: begin
          phase_q <= 32'h0000_0000;
          if (any_demand && !grid_back && !loss_stop) begin
            state_q <= gen_ctl_pkg::ST_WARMUP;
            by_manual_q <= manual_req;
          end
        end
        gen_ctl_pkg::ST_WARMUP: begin
          if (tick) begin
            phase_q <= phase_q + 32'h0000_0001;
          end
          if (!keep_run || loss_stop) begin
            state_q <= gen_ctl_pkg::ST_COOL;
            phase_q <= 32'h0000_0000;
          end else if (phase_q > warm_q) begin
            state_q <= manual_req ? gen_ctl_pkg::ST_MANUAL : gen_ctl_pkg::ST_COND;
          end
        end
        gen_ctl_pkg::ST_MANUAL, gen_ctl_pkg::ST_COND: begin
          state_q <= manual_req ? gen_ctl_pkg::ST_MANUAL : gen_ctl_pkg::ST_COND;
          // grid return disconnects first, then cools down
          if (grid_back && !manual_req) begin
            state_q <= gen_ctl_pkg::ST_COOL;
            phase_q <= 32'h0000_0000;
          end else if (loss_stop || (!keep_run && min_done)) begin
            state_q <= gen_ctl_pkg::ST_COOL;
            phase_q <= 32'h0000_0000;
          end
        end
        gen_ctl_pkg::ST_COOL: begin
          if (tick) begin
            phase_q <= phase_q + 32'h0000_0001;
          end
          if (phase_q > cool_q) begin
            state_q <= gen_ctl_pkg::ST_STOPPING;
            phase_q <= 32'h0000_0000;
          end
        end
        // extra settle time before counting as stopped
        gen_ctl_pkg::ST_STOPPING: begin
          if (tick) begin
            phase_q <= phase_q + 32'h0000_0001;
          end
          if (phase_q > 32'(`GRID_EXTRA_S)) begin
            state_q <= gen_ctl_pkg::ST_STOPPED;
            by_manual_q <= 1'b0;
          end
        end
        default: begin
          state_q <= gen_ctl_pkg::ST_STOPPED;
        end
      endcase
    end
  end

  logic running;
  assign running = state_q != gen_ctl_pkg::ST_STOPPED &&
    state_q != gen_ctl_pkg::ST_STOPPING;

  // relay drive; load only connected in manual and condition states
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      relay_out <= 1'b0;
      ac_connect_out <= 1'b0;
    end else begin
      relay_out <= running;
      ac_connect_out <= state_q == gen_ctl_pkg::ST_MANUAL ||
        state_q == gen_ctl_pkg::ST_COND;
    end
  end
  assign state_out = state_q;

  // ----------------------------------------
  // run counters
  // ----------------------------------------
  logic [31:0] total_s_q;
  logic [31:0] svc_s_q;
  logic run_tick;
  assign run_tick = tick && running;

  // current run restarts at each start
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || state_q == gen_ctl_pkg::ST_STOPPED) begin
      run_s_q <= 32'h0000_0000;
    end else if (run_tick) begin
      run_s_q <= run_s_q + 32'h0000_0001;
    end
  end

  // total seconds, overwritten by hours write
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      total_s_q <= 32'h0000_0000;
    end else if (wr_total) begin
      total_s_q <= 32'(wdata_in * 32'd3600);
    end else if (run_tick) begin
      total_s_q <= total_s_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      svc_s_q <= 32'h0000_0000;
    end else if (svc_reset) begin
      svc_s_q <= 32'(svc_int_q * 32'd3600);
    end else if (run_tick && svc_s_q != 32'h0000_0000) begin
      svc_s_q <= svc_s_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      service_warn_out <= 1'b0;
    end else begin
      service_warn_out <= svc_int_q != 32'h0000_0000 && svc_s_q == 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // daily history
  // ----------------------------------------
  logic [31:0] day_q [DAYS];

  // day zero accumulates, roll shifts history
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || day_reset) begin
      for (int i = 0; i < DAYS; i++) begin
        day_q[i] <= 32'h0000_0000;
      end
    end else if (day_roll) begin
      for (int i = 1; i < DAYS; i++) begin
        day_q[i] <= day_q[i - 1];
      end
      day_q[0] <= 32'h0000_0000;
    end else if (run_tick) begin
      day_q[0] <= day_q[0] + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // alarms
  // ----------------------------------------
  logic [31:0] noauto_q;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || auto_en) begin
      noauto_q <= 32'h0000_0000;
    end else if (tick && noauto_q <= 32'(`NOAUTO_LIMIT_S)) begin
      noauto_q <= noauto_q + 32'h0000_0001;
    end
  end

  // no power while expected; disabled too long
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      no_power_alarm_out <= 1'b0;
      no_auto_alarm_out <= 1'b0;
    end else begin
      no_power_alarm_out <= ctrl_q[`CTRL_DETECT] && !ac_power_s &&
        (state_q == gen_ctl_pkg::ST_MANUAL || state_q == gen_ctl_pkg::ST_COND);
      no_auto_alarm_out <= ctrl_q[`CTRL_NOAUTO_ALM] && noauto_q > 32'(`NOAUTO_LIMIT_S);
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // read data one cycle after strobe
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      rdata_out <= 32'h0000_0000;
      case (addr_in)
        `REG_CTRL: rdata_out <= ctrl_q;
        `REG_MIN_RUN: rdata_out <= min_run_q;
        `REG_WARM: rdata_out <= warm_q;
        `REG_COOL: rdata_out <= cool_q;
        `REG_SVC_INT: rdata_out <= svc_int_q;
        `REG_STATUS: rdata_out <= {4'h0, no_auto_alarm_out, no_power_alarm_out,
          service_warn_out, relay_out, 3'h0, active_cond_out, 6'h00, state_q};
        `REG_RUN_TIME: rdata_out <= run_s_q;
        `REG_TOTAL: rdata_out <= total_s_q;
        `REG_SVC_LEFT: rdata_out <= svc_s_q;
        default: begin
          for (int i = 0; i < DAYS; i++) begin
            if (addr_in == 8'(`REG_DAY_BASE + 4 * i)) begin
              rdata_out <= day_q[i];
            end
          end
        end
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

endmodule

// *** verification/gen_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// generator behind the start contact
// ----------------------------------------
module gen_model #(
  parameter int LAG = 20
) (
  input wire logic clk_sys_in,
  input wire logic relay_in,
  input wire logic fault_in,
  output logic ac_power_out
);
  int crank_q = 0;
  initial ac_power_out = 1'b0;
  // engine cranks while the contact is closed; a fault keeps it dead
  always @(posedge clk_sys_in) begin
    crank_q <= relay_in ? (crank_q < LAG ? crank_q + 1 : crank_q) : 0;
    ac_power_out <= relay_in && !fault_in && crank_q >= LAG;
  end
endmodule

// *** verification/gen_autostart_sva.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// port checker
// ----------------------------------------
module gen_autostart_sva #(
  parameter int unsigned CLK_HZ = 10
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic relay_out,
  input wire logic ac_connect_out,
  input wire logic [5:0] state_out,
  input wire logic [8:0] active_cond_out,
  input wire logic no_power_alarm_out
);
  localparam int SLO = 15 * CLK_HZ;
  localparam int SHI = 16 * CLK_HZ + 4;
  logic run_st;
  logic open_st;
  logic stop_st;
  int stop_cnt_q;
  // state groups
  assign run_st = state_out inside {gen_ctl_pkg::ST_WARMUP, gen_ctl_pkg::ST_MANUAL,
    gen_ctl_pkg::ST_COND, gen_ctl_pkg::ST_COOL};
  assign open_st = state_out inside {gen_ctl_pkg::ST_WARMUP, gen_ctl_pkg::ST_COOL};
  assign stop_st = state_out == gen_ctl_pkg::ST_STOPPING;
  // cycles spent in the stopping state
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !stop_st) begin
      stop_cnt_q <= 0;
    end else begin
      stop_cnt_q <= stop_cnt_q + 1;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  a_state_onehot: assert property ($onehot(state_out))
    else $error("run state not one-hot");
  a_active_single: assert property ($onehot0(active_cond_out))
    else $error("more than one active condition");
  a_relay_running: assert property (run_st [*2] |-> relay_out)
    else $error("relay off while running");
  a_relay_idle: assert property ((state_out == gen_ctl_pkg::ST_STOPPED) [*2] |-> !relay_out)
    else $error("relay on while stopped");
  a_open_warm_cool: assert property (open_st [*2] |-> !ac_connect_out)
    else $error("load connected in warm-up or cool-down");
  a_stop_len: assert property ($fell(stop_st) |-> stop_cnt_q >= SLO && stop_cnt_q <= SHI)
    else $error("stopping period length wrong");
  a_stop_exit: assert property (stop_st |=> stop_st || state_out == gen_ctl_pkg::ST_STOPPED)
    else $error("stopping left for a running state");
  a_alarm_running: assert property (no_power_alarm_out |-> $past(relay_out) || $past(relay_out, 2))
    else $error("no-power alarm without generator run");
  a_rdata_quiet: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read cycle");
endmodule

bind gen_autostart gen_autostart_sva #(.CLK_HZ(CLK_HZ)) sva_i (.clk_sys_in(clk_sys_in),
  .reset_in(reset_in), .rd_in(rd_in), .rdata_out(rdata_out), .relay_out(relay_out),
  .ac_connect_out(ac_connect_out), .state_out(state_out), .active_cond_out(active_cond_out),
  .no_power_alarm_out(no_power_alarm_out));

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
`include "gen_ctl_defs.svh"
module tb_top;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] demand = 7'h00;
  logic lost = 1'b0;
  logic grid1 = 1'b0;
  logic grid2 = 1'b0;
  logic fault = 1'b0;
  logic ac_power, relay, connect, warn, nopwr, noauto;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [5:0] state;
  logic [8:0] active;
  int err_total = 0;
  int check_count = 0;
  int n;
  always #5 clk_sys_in = ~clk_sys_in;
  gen_autostart #(.CLK_HZ(10), .DAYS(7)) dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .cond_demand_in(demand), .comm_lost_in(lost), .ac_power_in(ac_power),
    .grid_ac1_in(grid1), .grid_ac2_in(grid2), .relay_out(relay), .ac_connect_out(connect),
    .state_out(state), .active_cond_out(active), .service_warn_out(warn),
    .no_power_alarm_out(nopwr), .no_auto_alarm_out(noauto));
  gen_model #(.LAG(20)) gen (.clk_sys_in(clk_sys_in), .relay_in(relay), .fault_in(fault),
    .ac_power_out(ac_power));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // bounded wait for a state; n returns cycles waited
  task automatic wait_st(input logic [5:0] s, input int lim, output int n);
    for (n = 0; n < lim && state !== s; n++) @(negedge clk_sys_in);
    if (state !== s) begin
      chk(32'(state), 32'(s));
      report_and_stop();
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(32'(state), 32'(gen_ctl_pkg::ST_STOPPED));
    chk({27'h0, relay, connect, warn, nopwr, noauto}, 32'h0);
    rreg(`REG_CTRL, v);
    chk(v, `CTRL_RESET);
    rreg(`REG_WARM, v);
    chk(v, `WARM_RESET);
    rreg(`REG_COOL, v);
    chk(v, `COOL_RESET);
    rreg(8'hfc, v);
    chk(v, 32'h0);
  endtask
  // manual run with a min run that must be ignored
  task automatic t_manual();
    wreg(`REG_WARM, 32'h1);
    wreg(`REG_COOL, 32'h1);
    wreg(`REG_MIN_RUN, 32'h1e);
    wreg(`REG_CTRL, 32'h7);
    wait_st(gen_ctl_pkg::ST_WARMUP, 40, n);
    wait_st(gen_ctl_pkg::ST_MANUAL, 40, n);
    chk(32'(n >= 11 && n <= 22), 32'h1);
    chk({23'h0, active}, 32'h100);
    repeat (30) @(negedge clk_sys_in);
    chk({30'h0, connect, nopwr}, 32'h2);
    rreg(`REG_RUN_TIME, v);
    chk(32'(v >= 2 && v <= 6), 32'h1);
    wreg(`REG_CTRL, 32'h5);
    wait_st(gen_ctl_pkg::ST_COOL, 8, n);
    wait_st(gen_ctl_pkg::ST_STOPPING, 30, n);
    wait_st(gen_ctl_pkg::ST_STOPPED, 200, n);
    chk(32'(n >= 150 && n <= 162), 32'h1);
    rreg(`REG_TOTAL, v);
    chk(32'(v >= 2), 32'h1);
    rreg(`REG_DAY_BASE, v);
    chk(32'(v >= 2), 32'h1);
  endtask
  // ranked conditions, min run, lower demand and manual holding the run
  task automatic t_cond();
    wreg(`REG_MIN_RUN, 32'h6);
    demand <= 7'h05;
    wait_st(gen_ctl_pkg::ST_COND, 80, n);
    rreg(`REG_RUN_TIME, v);
    chk(32'(v <= 2), 32'h1);
    chk({23'h0, active}, 32'h004);
    demand <= 7'h00;
    repeat (8) @(negedge clk_sys_in);
    chk(32'(state), 32'(gen_ctl_pkg::ST_COND));
    demand <= 7'h41;
    repeat (40) @(negedge clk_sys_in);
    chk({23'h0, active}, 32'h040);
    demand <= 7'h01;
    repeat (4) @(negedge clk_sys_in);
    chk({23'h0, active}, 32'h001);
    chk(32'(state), 32'(gen_ctl_pkg::ST_COND));
    wreg(`REG_CTRL, 32'h7);
    demand <= 7'h00;
    repeat (8) @(negedge clk_sys_in);
    chk(32'(state), 32'(gen_ctl_pkg::ST_MANUAL));
    wreg(`REG_CTRL, 32'h5);
    wait_st(gen_ctl_pkg::ST_COOL, 60, n);
    chk(32'(n <= 5), 32'h1);
    wait_st(gen_ctl_pkg::ST_STOPPED, 250, n);
  endtask
  // autostart off: no condition start, alarm after ten minutes
  task automatic t_noauto();
    wreg(`REG_CTRL, 32'h8);
    demand <= 7'h7f;
    repeat (5900) @(negedge clk_sys_in);
    chk(32'(state), 32'(gen_ctl_pkg::ST_STOPPED));
    chk({31'h0, noauto}, 32'h0);
    repeat (300) @(negedge clk_sys_in);
    chk({31'h0, noauto}, 32'h1);
    demand <= 7'h00;
    wreg(`REG_CTRL, 32'h1);
    repeat (5) @(negedge clk_sys_in);
    chk({31'h0, noauto}, 32'h0);
  endtask
  // link loss with start, stop and keep actions
  task automatic t_loss();
    wreg(`REG_CTRL, 32'h11);
    lost <= 1'b1;
    wait_st(gen_ctl_pkg::ST_WARMUP, 60, n);
    repeat (40) @(negedge clk_sys_in);
    wreg(`REG_CTRL, 32'h1);
    wait_st(gen_ctl_pkg::ST_COOL, 60, n);
    wait_st(gen_ctl_pkg::ST_STOPPED, 250, n);
    wreg(`REG_CTRL, 32'h21);
    repeat (50) @(negedge clk_sys_in);
    chk(32'(state), 32'(gen_ctl_pkg::ST_STOPPED));
    lost <= 1'b0;
  endtask
  // grid return on the selected input only
  task automatic t_grid();
    wreg(`REG_CTRL, 32'h41);
    demand <= 7'h01;
    wait_st(gen_ctl_pkg::ST_COND, 80, n);
    grid2 <= 1'b1;
    repeat (10) @(negedge clk_sys_in);
    chk(32'(state), 32'(gen_ctl_pkg::ST_COND));
    grid1 <= 1'b1;
    wait_st(gen_ctl_pkg::ST_COOL, 10, n);
    wait_st(gen_ctl_pkg::ST_STOPPED, 250, n);
    {demand, grid1, grid2} <= 9'h000;
  endtask
  // dead generator, counters and history
  task automatic t_misc();
    fault <= 1'b1;
    wreg(`REG_CTRL, 32'h7);
    wait_st(gen_ctl_pkg::ST_MANUAL, 60, n);
    repeat (30) @(negedge clk_sys_in);
    chk({31'h0, nopwr}, 32'h1);
    wreg(`REG_CTRL, 32'h1);
    wait_st(gen_ctl_pkg::ST_STOPPED, 250, n);
    fault <= 1'b0;
    wreg(`REG_SVC_INT, 32'h1);
    repeat (2) @(negedge clk_sys_in);
    chk({31'h0, warn}, 32'h1);
    wreg(`REG_CMD, 32'h1);
    rreg(`REG_SVC_LEFT, v);
    chk(v, 32'he10);
    chk({31'h0, warn}, 32'h0);
    wreg(`REG_TOTAL_SET, 32'h2);
    rreg(`REG_TOTAL, v);
    chk(v, 32'h1c20);
    wreg(`REG_CMD, 32'h4);
    rreg(8'(`REG_DAY_BASE + 4), v);
    chk(32'(v >= 2), 32'h1);
    rreg(`REG_DAY_BASE, v);
    chk(v, 32'h0);
    wreg(`REG_CMD, 32'h2);
    for (int i = 0; i < 7; i++) begin
      rreg(8'(`REG_DAY_BASE + 4 * i), v);
      chk(v, 32'h0);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(negedge clk_sys_in);
    t_reset();
    t_manual();
    t_cond();
    t_noauto();
    t_loss();
    t_grid();
    t_misc();
    report_and_stop();
  end
endmodule
